// File: adc_seq_defs.vh
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// Register byte offsets on the APB bus.
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_CTRL2 12'h008
`define OFS_RES_HI 12'h00c
`define OFS_RES_LO 12'h010
`define OFS_IRQ 12'h014
`define OFS_SYS 12'h018

// Control register 0 fields.
`define C0_PWR 0
`define C0_BUSY 1
`define C0_CH_LO 2
`define C0_CH_HI 6

// Control register 1 fields.
`define C1_JUST 7
`define C1_CS_LO 4
`define C1_CS_HI 6
`define C1_WMASK 8'hf7

// Control register 2 fields.
`define C2_TS_LO 4
`define C2_TS_HI 7

// Interrupt register: done flag bit 0, irq enable bit 1.
`define IRQ_DONE 0
`define IRQ_EN 1

// Reset values.
`define RST_CTRL0 7'h00
`define RST_CTRL1 8'h00
`define RST_CTRL2 4'h0

// Conversion timing: 11.5 bit periods counted in half periods.
`define CONV_HALF_PERIODS 5'd23
`define RC_START_DELAY 8'd4

`endif

// File: adc_clock_divider.v
`timescale 1ns/10ps
`include "adc_seq_defs.vh"

// Makes a one-cycle tick every half bit-conversion period.
module adc_clock_divider #(
	parameter RC_HALF = 8'd20
) (
	// Clock and control
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	input wire run,
	input wire [2:0] conv_clock_sel,
	// Tick output
	output reg half_tick
);

	reg [7:0] cnt_reg;
	reg [7:0] half_len;

	// -----------------------------------------------------------
	// Divider selection
	// -----------------------------------------------------------
	// clock encoding
	always @* begin
		case (conv_clock_sel)
		3'b000: half_len = 8'd1;
		3'b100: half_len = 8'd2;
		3'b001: half_len = 8'd4;
		3'b101: half_len = 8'd8;
		3'b010: half_len = 8'd16;
		3'b110: half_len = 8'd32;
		default: half_len = RC_HALF;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			half_tick <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				cnt_reg <= 8'h00;
				half_tick <= 1'b0;
			end else if (cnt_reg + 8'd1 >= half_len) begin
				cnt_reg <= 8'h00;
				half_tick <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 8'd1;
				half_tick <= 1'b0;
			end
		end
	end

endmodule

// File: adc_conversion_sequencer.v
`timescale 1ns/10ps
`include "adc_seq_defs.vh"

// Functional notes
// - Done flag set at normal conversion end, not on abort
// - Enabled interrupt wakes sleeping core on completion
// - Power follows enable; start bit begins conversion
// - Completion clears busy, sets flag, loads result
// - Clearing busy aborts, fills partial result
// - Reset restores registers, stops converter
// - RC clock delays start one instruction
// - Sleep, irq off: power down after conversion
// - Sleep on non-RC clock aborts conversion
// - Trigger rising edge sets busy bit
// - Four-bit trigger select in control two
// - Five-bit channel select, bits six to two
// - Busy bit one reads conversion in progress
// - Enable zero powers converter off
// - Control zero bit seven reads zero
// - Result justified per format bit
// - Sleep conversion only with RC clock
// - Trigger select encoding table
// - Justified result pads six zero bits
// - Conversion lasts 11.5 bit periods
// - Three-bit conversion clock select encoding
module adc_conversion_sequencer #(
	parameter RC_HALF = 8'd20
) (
	// Clock, enable, reset
	input wire clk_sys,
	input wire clk_en,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Core state
	input wire core_sleeping,
	output reg wake_request,
	// Trigger sources, index equals select code
	input wire [13:1] trigger_in,
	// Analog core
	output reg converter_power_on,
	output reg [4:0] channel_sel,
	output reg sample_hold,
	output reg [9:0] trial_code,
	input wire comparator_high
);

	// ---------------------------------------------------------
	// State
	// ---------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_CONV = 3'b100;

	reg [2:0] state_reg;
	reg [6:0] ctrl0_reg;
	reg [7:0] ctrl1_reg;
	reg [3:0] ctrl2_reg;
	reg [7:0] result_high_reg;
	reg [7:0] result_low_reg;
	reg conv_done_flag;
	reg conv_irq_enable;
	reg [13:1] trig_prev_reg;
	reg [9:0] sar_reg;
	reg [4:0] half_cnt_reg;
	reg [7:0] wait_cnt_reg;
	reg sleep_off_reg;
	reg [3:0] last_bit_reg;

	wire half_tick;
	wire [4:0] cur_bit;
	wire rc_clk;
	wire busy;
	wire power_en;
	wire wr_access;
	wire rd_access;
	wire trig_edge;
	wire [13:1] trig_rise;
	reg [9:0] fill_next;
	reg [9:0] final_next;
	reg [31:0] rdata_next;
	integer i;

	assign busy = ctrl0_reg[`C0_BUSY];
	assign rc_clk = (ctrl1_reg[5:4] == 2'b11);
	assign power_en = ctrl0_reg[`C0_PWR] & ~sleep_off_reg;
	assign wr_access = psel & penable & pwrite & ~pready;
	assign rd_access = psel & penable & ~pwrite & ~pready;
	assign trig_rise = trigger_in & ~trig_prev_reg;
	assign trig_edge = (ctrl2_reg >= 4'd1) && (ctrl2_reg <= 4'd13) &&
		trig_rise[ctrl2_reg];
	assign cur_bit = 5'd9 - {1'b0, half_cnt_reg[4:1]};

	adc_clock_divider #(
		.RC_HALF(RC_HALF)
	) u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(state_reg == ST_CONV),
		.conv_clock_sel(ctrl1_reg[`C1_CS_HI:`C1_CS_LO]),
		.half_tick(half_tick)
	);

	// ---------------------------------------------------------
	// Result formation
	// ---------------------------------------------------------
	// partial fill
	always @* begin
		fill_next = sar_reg;
		for (i = 0; i < 10; i = i + 1) begin
			if (i < 9 - last_bit_reg)
				fill_next[i] = sar_reg[9 - last_bit_reg];
		end
		final_next = sar_reg;
		if (!comparator_high && half_cnt_reg[0] == 1'b1 &&
			half_cnt_reg < 5'd20)
			final_next[cur_bit[3:0]] = 1'b0;
	end

	// ---------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------
	always @* begin
		rdata_next = 32'h0000_0000;
		if (paddr == `OFS_CTRL0)
			rdata_next[6:0] = ctrl0_reg;
		else if (paddr == `OFS_CTRL1)
			rdata_next[7:0] = ctrl1_reg & `C1_WMASK;
		else if (paddr == `OFS_CTRL2)
			rdata_next[7:4] = ctrl2_reg;
		else if (paddr == `OFS_RES_HI)
			rdata_next[7:0] = result_high_reg;
		else if (paddr == `OFS_RES_LO)
			rdata_next[7:0] = result_low_reg;
		else if (paddr == `OFS_IRQ)
			rdata_next[1:0] = {conv_irq_enable, conv_done_flag};
		else if (paddr == `OFS_SYS)
			rdata_next[1:0] = {core_sleeping, converter_power_on};
	end

	// ---------------------------------------------------------
	// Main process
	// ---------------------------------------------------------
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			ctrl0_reg <= `RST_CTRL0;
			ctrl1_reg <= `RST_CTRL1;
			ctrl2_reg <= `RST_CTRL2;
			result_high_reg <= 8'h00;
			result_low_reg <= 8'h00;
			conv_done_flag <= 1'b0;
			conv_irq_enable <= 1'b0;
			trig_prev_reg <= 13'h0000;
			sar_reg <= 10'h000;
			half_cnt_reg <= 5'd0;
			wait_cnt_reg <= 8'd0;
			sleep_off_reg <= 1'b0;
			last_bit_reg <= 4'd0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			wake_request <= 1'b0;
			converter_power_on <= 1'b0;
			channel_sel <= 5'd0;
			sample_hold <= 1'b0;
			trial_code <= 10'h000;
		end else if (clk_en) begin
			trig_prev_reg <= trigger_in;
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			wake_request <= 1'b0;
			if (!core_sleeping)
				sleep_off_reg <= 1'b0;
			if (rd_access)
				prdata <= rdata_next;
			if (psel & penable & ~pready &&
				paddr > `OFS_SYS)
				pslverr <= 1'b1;

			// Register writes.
			if (wr_access && paddr == `OFS_CTRL0)
				ctrl0_reg <= pwdata[6:0];
			if (wr_access && paddr == `OFS_CTRL1)
				ctrl1_reg <= pwdata[7:0] & `C1_WMASK;
			if (wr_access && paddr == `OFS_CTRL2)
				ctrl2_reg <= pwdata[`C2_TS_HI:`C2_TS_LO];
			if (wr_access && paddr == `OFS_RES_HI)
				result_high_reg <= pwdata[7:0];
			if (wr_access && paddr == `OFS_RES_LO)
				result_low_reg <= pwdata[7:0];
			if (wr_access && paddr == `OFS_IRQ) begin
				conv_irq_enable <= pwdata[`IRQ_EN];
				if (!pwdata[`IRQ_DONE])
					conv_done_flag <= 1'b0;
			end

			if (trig_edge && state_reg == ST_IDLE &&
				ctrl0_reg[`C0_PWR])
				ctrl0_reg[`C0_BUSY] <= 1'b1;

			case (state_reg)
			ST_IDLE: begin
				// start on busy set while powered
				if (busy && power_en) begin
					sar_reg <= 10'h200;
					half_cnt_reg <= 5'd0;
					last_bit_reg <= 4'd0;
					wait_cnt_reg <= rc_clk ? `RC_START_DELAY : 8'd0;
					state_reg <= ST_WAIT;
				end else if (busy) begin
					ctrl0_reg[`C0_BUSY] <= 1'b0;
				end
			end
			ST_WAIT: begin
				if (wait_cnt_reg == 8'd0) begin
					state_reg <= ST_CONV;
				end else begin
					wait_cnt_reg <= wait_cnt_reg - 8'd1;
				end
			end
			ST_CONV: begin
				if (half_tick) begin
					half_cnt_reg <= half_cnt_reg + 5'd1;
					// Odd half periods decide one trial bit.
					if (half_cnt_reg[0] && half_cnt_reg < 5'd20) begin
						sar_reg <= final_next;
						last_bit_reg <= 4'd9 - cur_bit[3:0];
						if (cur_bit != 5'd0)
							sar_reg[cur_bit[3:0] - 4'd1] <= 1'b1;
					end
				end
			end
			default: state_reg <= ST_IDLE;
			endcase

			// abort in sleep without RC clock
			if (state_reg != ST_IDLE && core_sleeping && !rc_clk) begin
				state_reg <= ST_IDLE;
				ctrl0_reg[`C0_BUSY] <= 1'b0;
				sleep_off_reg <= 1'b1;
			end else if (state_reg == ST_CONV && wr_access &&
				paddr == `OFS_CTRL0 && !pwdata[`C0_BUSY]) begin
				state_reg <= ST_IDLE;
				result_high_reg <= ctrl1_reg[`C1_JUST] ?
					{6'h00, fill_next[9:8]} : fill_next[9:2];
				result_low_reg <= ctrl1_reg[`C1_JUST] ?
					fill_next[7:0] : {fill_next[1:0], 6'h00};
			end else if (state_reg != ST_IDLE && !ctrl0_reg[`C0_PWR]) begin
				state_reg <= ST_IDLE;
				ctrl0_reg[`C0_BUSY] <= 1'b0;
			end else if (state_reg == ST_CONV && half_tick &&
				half_cnt_reg == `CONV_HALF_PERIODS - 5'd1) begin
				state_reg <= ST_IDLE;
				ctrl0_reg[`C0_BUSY] <= 1'b0;
				conv_done_flag <= 1'b1;
				result_high_reg <= ctrl1_reg[`C1_JUST] ?
					{6'h00, sar_reg[9:8]} : sar_reg[9:2];
				result_low_reg <= ctrl1_reg[`C1_JUST] ?
					sar_reg[7:0] : {sar_reg[1:0], 6'h00};
				if (core_sleeping && conv_irq_enable)
					wake_request <= 1'b1;
				if (core_sleeping && !conv_irq_enable)
					sleep_off_reg <= 1'b1;
			end

			converter_power_on <= power_en;
			channel_sel <= ctrl0_reg[`C0_CH_HI:`C0_CH_LO];
			// Falls with power so the hold never outlives the supply.
			sample_hold <= (state_reg == ST_CONV) && power_en;
			trial_code <= sar_reg;
		end
	end

endmodule

// File: adc_core_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Comparator stand-in
// ----------------------------------------
// Outside a conversion the answer is the inverted trial code bit 0, so a stale read shows.
module adc_core_model (
	// Analog core
	input wire logic [9:0] trial_code,
	input wire logic sample_hold,
	input wire logic [9:0] level,
	output logic comparator_high
);
	assign comparator_high = sample_hold ? (level >= trial_code) :
		~trial_code[0];
endmodule

// File: adc_seq_sva.sv
`timescale 1ns/10ps
`include "adc_seq_defs.vh"
module adc_seq_sva (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Core side
	input wire core_sleeping,
	input wire wake_request,
	input wire converter_power_on,
	input wire sample_hold,
	input wire [9:0] trial_code
);
	default clocking cb @(posedge clk_sys);
	endclocking
	// Marks a conversion that software or sleep may have cut short.
	logic cut_reg = 1'b0;
	always @(posedge clk_sys) begin
		if (!sample_hold)
			cut_reg <= 1'b0;
		else if (core_sleeping || (psel && pwrite && paddr == `OFS_CTRL0))
			cut_reg <= 1'b1;
	end
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_ctrl0_read;
		pready && !pwrite && paddr == `OFS_CTRL0;
	endsequence
	a_pready_wait:
	assert property (disable iff (!rst_n) s_access |=> pready)
	else $error("no answer after access");
	a_pready_pulse:
	assert property (disable iff (!rst_n) pready |=> !pready)
	else $error("answer held too long");
	a_bit7_zero:
	assert property (disable iff (!rst_n) s_ctrl0_read |-> !prdata[7])
	else $error("control bit seven read as one");
	a_reset_bus:
	assert property (!rst_n |=> !pready && !pslverr && prdata == 32'h0)
	else $error("bus outputs not cleared by reset");
	a_reset_power:
	assert property (!rst_n |=> !converter_power_on && !sample_hold)
	else $error("converter still active after reset");
	a_hold_powered:
	assert property (disable iff (!rst_n) sample_hold |-> converter_power_on)
	else $error("conversion without power");
	a_conv_length:
	assert property (disable iff (!rst_n) $fell(sample_hold) |->
		cut_reg || $past(sample_hold, 20))
	else $error("conversion ended too early");
	a_wake_pulse:
	assert property (disable iff (!rst_n) wake_request |=> !wake_request)
	else $error("wake request longer than one cycle");
	a_wake_sleep:
	assert property (disable iff (!rst_n)
		wake_request |-> $past(core_sleeping))
	else $error("wake request while awake");
endmodule
bind adc_conversion_sequencer adc_seq_sva adc_seq_sva_i (.clk_sys, .rst_n,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.core_sleeping, .wake_request, .converter_power_on, .sample_hold,
	.trial_code);

// File: tb_adc_conversion_sequencer.sv
`timescale 1ns/10ps
`include "adc_seq_defs.vh"
`define CHK(n, s, e) begin checks++; if ((s) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_adc_conversion_sequencer;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic core_sleeping = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [13:1] trigger_in = 13'h0;
	logic [9:0] level = 10'h2a5;
	logic [7:0] rd;
	logic err;
	wire [31:0] prdata;
	wire pready, pslverr, wake_request, converter_power_on;
	wire sample_hold, comparator_high;
	wire [4:0] channel_sel;
	wire [9:0] trial_code;
	int failures = 0;
	int checks = 0;
	adc_conversion_sequencer #(.RC_HALF(8'd2)) adc_conversion_sequencer_i (
		.clk_sys, .clk_en(1'b1), .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .core_sleeping, .wake_request,
		.trigger_in, .converter_power_on, .channel_sel, .sample_hold,
		.trial_code, .comparator_high);
	adc_core_model adc_core_model_i (.trial_code, .sample_hold, .level,
		.comparator_high);
	// ----------------------------------------
	// Bus and control tasks
	// ----------------------------------------
	task automatic conclude;
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic stall;
		failures++;
		conclude;
	endtask
	// The idle edge at the end keeps two requests from meeting in one step.
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) stall;
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, `OFS_CTRL0, 8'h00);
			n++;
		end while (rd[1] !== 1'b0 && n < 300);
		if (rd[1] !== 1'b0) stall;
	endtask
	task automatic start(input logic [7:0] c1);
		bus(1'b1, `OFS_CTRL1, c1);
		bus(1'b1, `OFS_CTRL0, 8'h00);
		bus(1'b1, `OFS_CTRL0, 8'h01);
		repeat (4) @(posedge clk_sys);
		bus(1'b1, `OFS_CTRL0, 8'h03);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		`CHK("power", converter_power_on, 1'b0)
		bus(1'b0, `OFS_CTRL0, 8'h00);
		`CHK("ctrl0", rd, 8'h00)
		bus(1'b0, `OFS_CTRL2, 8'h00);
		`CHK("ctrl2", rd, 8'h00)
		bus(1'b0, 12'h01c, 8'h00);
		`CHK("unmapped", err, 1'b1)
		bus(1'b1, `OFS_CTRL0, 8'hfc);
		bus(1'b0, `OFS_CTRL0, 8'h00);
		`CHK("ctrl0 bit7", rd, 8'h7c)
		`CHK("channel", channel_sel, 5'h1f)
		`CHK("power off", converter_power_on, 1'b0)
	endtask
	task automatic t_conv(input logic j);
		logic [7:0] hi, lo;
		hi = j ? {6'h0, level[9:8]} : level[9:2];
		lo = j ? level[7:0] : {level[1:0], 6'h0};
		start({j, 7'h00});
		`CHK("power", converter_power_on, 1'b1)
		wait_idle;
		`CHK("trial", trial_code, level)
		bus(1'b0, `OFS_RES_HI, 8'h00);
		`CHK("res hi", rd, hi)
		bus(1'b0, `OFS_RES_LO, 8'h00);
		`CHK("res lo", rd, lo)
		bus(1'b0, `OFS_IRQ, 8'h00);
		`CHK("done", rd[0], 1'b1)
		bus(1'b1, `OFS_IRQ, 8'h00);
		bus(1'b0, `OFS_IRQ, 8'h00);
		`CHK("cleared", rd[0], 1'b0)
	endtask
	task automatic t_abort;
		level = 10'h3c0;
		start(8'hd0);
		repeat (40) @(posedge clk_sys);
		bus(1'b1, `OFS_CTRL0, 8'h01);
		wait_idle;
		bus(1'b0, `OFS_RES_LO, 8'h00);
		`CHK("partial lo", rd, 8'hff)
		bus(1'b0, `OFS_RES_HI, 8'h00);
		`CHK("partial hi", rd, 8'h03)
	endtask
	task automatic t_trig;
		bus(1'b1, `OFS_CTRL1, 8'h80);
		bus(1'b1, `OFS_CTRL0, 8'h01);
		for (int n = 1; n <= 13; n++) begin
			bus(1'b1, `OFS_CTRL2, 8'(n << 4));
			trigger_in[n] <= 1'b1;
			repeat (3) @(posedge clk_sys);
			bus(1'b0, `OFS_CTRL0, 8'h00);
			`CHK("trig busy", rd[1], 1'b1)
			trigger_in[n] <= 1'b0;
			bus(1'b0, `OFS_CTRL0, 8'h00);
			trigger_in[n] <= 1'b1;
			wait_idle;
			trigger_in <= 13'h0;
			bus(1'b0, `OFS_CTRL0, 8'h00);
			`CHK("no retrigger", rd[1], 1'b0)
		end
		bus(1'b1, `OFS_CTRL2, 8'he0);
		bus(1'b0, `OFS_CTRL2, 8'h00);
		`CHK("trig sel", rd, 8'he0)
		trigger_in <= 13'h1fff;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, `OFS_CTRL0, 8'h00);
		`CHK("reserved idle", rd[1], 1'b0)
		trigger_in <= 13'h0;
		bus(1'b1, `OFS_CTRL2, 8'h00);
		trigger_in <= 13'h1fff;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, `OFS_CTRL0, 8'h00);
		`CHK("none idle", rd[1], 1'b0)
		trigger_in <= 13'h0;
	endtask
	task automatic t_sleep;
		bus(1'b1, `OFS_IRQ, 8'h02);
		start(8'hb0);
		core_sleeping <= 1'b1;
		for (int n = 0; n < 300 && wake_request !== 1'b1; n++)
			@(posedge clk_sys);
		`CHK("wake", wake_request, 1'b1)
		bus(1'b1, `OFS_IRQ, 8'h00);
		start(8'hb0);
		wait_idle;
		`CHK("rc sleep off", converter_power_on, 1'b0)
		`CHK("enable kept", rd[0], 1'b1)
		bus(1'b0, `OFS_SYS, 8'h00);
		`CHK("status", rd[1:0], 2'b10)
		core_sleeping <= 1'b0;
		start(8'h60);
		repeat (12) @(posedge clk_sys);
		core_sleeping <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus(1'b0, `OFS_CTRL0, 8'h00);
		`CHK("sleep abort", rd[1:0], 2'b01)
		`CHK("sleep off", converter_power_on, 1'b0)
		core_sleeping <= 1'b0;
	endtask
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_conv(1'b0);
		t_conv(1'b1);
		t_abort;
		t_trig;
		t_sleep;
		conclude;
	end
endmodule
